// ---- verilog/lps_pin_select.sv ----
`default_nettype none
// Behaviour
// - select bit 1 routes pin to indicator
// - function code picks displayed status function
// - function code ignored on general-purpose pins
// - indicator pins: pull-up, input buffer off
// - code 11b push-pull, else open-drain/source
// - open-drain indicator active low on high strap
// - polarity from hard strap, never loader
// - general-purpose pins follow gpio settings only
// - defaults latched from straps on first edge after reset release
// - loader may replace strap-derived defaults
// - open-drain gpio: low on 0, released 1
module lps_pin_select
    import lps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    // register port of the serial management path
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // configuration straps, sampled on the first edge after rst goes low
    input wire logic [1:0] function_default_strap,
    input wire logic [5:0] select_default_strap,
    input wire logic [5:0] polarity_strap,
    // loader override
    input wire lps_loader_type loader,
    // indicator status per function code, one bit per pin
    input wire logic [3:0][5:0] indicator_status,
    // general-purpose pin logic
    input wire lps_gpio_cfg_type gpio_cfg,
    output logic [5:0] gpio_pin_in,
    // the shared pins
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    output logic [5:0] pin_pullup_en,
    output logic [5:0] pin_ibuf_en,
    // which pins currently run as indicators
    output logic [5:0] indicator_select_bits
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // everything the block remembers lives in one record
    typedef struct packed {
        lps_phase_type phase;        // strap capture or running
        logic [5:0] sel;             // indicator select bits
        logic [1:0] fun;             // indicator function code
        logic [5:0] pol_low;         // hard-strap polarity
        logic [31:0] rdata;          // read answer
        logic rvalid;                // read answer strobe
        logic [5:0] pin_out;         // registered pin level
        logic [5:0] pin_oe;          // registered enable
        logic [5:0] pin_pullup_en;   // registered pull-up
        logic [5:0] pin_ibuf_en;     // registered input buffer
        logic [5:0] gpio_in;         // sampled pin for gpio
    } lps_state_type;

    lps_state_type state;       // current record
    lps_state_type next_state;  // record for the next edge

    // per-pin drive requests from the pin drivers
    lps_pin_drive_type [5:0] drive;

    // indicator level chosen by the function code
    logic [5:0] status_selected;

    // ------------------------------------------------------------
    // indicator function choice
    // ------------------------------------------------------------
    // the full status table sits outside; here the code only
    // picks which row of it reaches the pins
    always_comb begin
        status_selected = indicator_status[state.fun];
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // one driver per pin; the select bit decides whether the
    // function code or the gpio settings steer it
    for (genvar i = 0; i < LPS_PIN_COUNT; i++) begin : g_pin
        lps_pin_driver u_driver (
            .indicator_sel(state.sel[i]),
            .function_code(state.fun),
            .polarity_low(state.pol_low[i]),
            .indicator_active(status_selected[i]),
            .gpio_push_pull(gpio_cfg.push_pull[i]),
            .gpio_dir_out(gpio_cfg.dir_out[i]),
            .gpio_data(gpio_cfg.data_out[i]),
            .drive(drive[i])
        );
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.rvalid = 1'b0;

        case (state.phase)
            // first edge after reset release: take the straps
            LPS_PH_LATCH: begin
                next_state.sel = select_default_strap;
                next_state.fun = function_default_strap;
                // polarity is caught here only and never again
                next_state.pol_low = polarity_strap;
                next_state.phase = LPS_PH_RUN;
            end
            // normal operation
            LPS_PH_RUN: begin
                if (loader.valid) begin
                    // loader override wins over a software write
                    // in the same cycle; it only comes at boot
                    next_state.sel = loader.sel;
                    next_state.fun = loader.fun;
                end else if (reg_wr && lps_hits_config(reg_addr)) begin
                    // reserved bits of the write are dropped
                    next_state.sel = reg_wdata[LPS_SEL_LSB +: 6];
                    next_state.fun = reg_wdata[LPS_FUN_LSB +: 2];
                end
            end
            default: begin
                next_state.phase = LPS_PH_LATCH;
            end
        endcase

        // read answer: the live configuration, or zero when the
        // address is not ours
        if (reg_rd) begin
            next_state.rvalid = 1'b1;
            if (lps_hits_config(reg_addr)) begin
                next_state.rdata = lps_config_word(state.fun, state.sel);
            end else begin
                next_state.rdata = LPS_WORD_ZERO;
            end
        end

        // pin outputs come from flops, so they follow the
        // configuration one edge later; a glitch-free pin was
        // worth the single cycle of lag
        for (int i = 0; i < LPS_PIN_COUNT; i++) begin
            if (state.phase == LPS_PH_RUN) begin
                next_state.pin_out[i] = drive[i].out;
                next_state.pin_oe[i] = drive[i].oe;
                next_state.pin_pullup_en[i] = drive[i].pullup_en;
                next_state.pin_ibuf_en[i] = drive[i].ibuf_en;
            end else begin
                // hold pins released until the straps are known
                next_state.pin_out[i] = 1'b0;
                next_state.pin_oe[i] = 1'b0;
                next_state.pin_pullup_en[i] = 1'b1;
                next_state.pin_ibuf_en[i] = 1'b1;
            end
            // gpio logic sees the pin only while its buffer is on;
            // an indicator pin reads as zero
            next_state.gpio_in[i] = pin_in[i] & state.pin_ibuf_en[i];
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset to constants; the straps are taken by
    // the latch phase right after release, not under reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state.phase <= LPS_PH_LATCH;
            state.sel <= LPS_SEL_RESET;
            state.fun <= LPS_FUN_RESET;
            state.pol_low <= LPS_POL_RESET;
            state.rdata <= LPS_WORD_ZERO;
            state.rvalid <= 1'b0;
            state.pin_out <= 6'h00;
            state.pin_oe <= 6'h00;
            state.pin_pullup_en <= 6'h3f;
            state.pin_ibuf_en <= 6'h3f;
            state.gpio_in <= 6'h00;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // each output is a field of the state record
    always_comb begin
        reg_rdata = state.rdata;
        reg_rvalid = state.rvalid;
        pin_out = state.pin_out;
        pin_oe = state.pin_oe;
        pin_pullup_en = state.pin_pullup_en;
        pin_ibuf_en = state.pin_ibuf_en;
        gpio_pin_in = state.gpio_in;
        indicator_select_bits = state.sel;
    end

endmodule
`default_nettype wire

// ---- verilog/lps_pkg.sv ----
`default_nettype none
package lps_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned LPS_ADDR_W = 16;
    // byte address of the indicator pin configuration register
    localparam logic [15:0] LPS_ADDR_PIN_CONFIG = 16'h01bc;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int unsigned LPS_PIN_COUNT = 6;
    localparam int unsigned LPS_SEL_LSB = 0;   // select bits 5:0
    localparam int unsigned LPS_FUN_LSB = 8;   // function code 9:8
    // function code that asks for push-pull indicator drive
    localparam logic [1:0] LPS_FUN_PUSH_PULL = 2'h3;

    // ------------------------------------------------------------
    // values held during reset, before the straps are taken
    // ------------------------------------------------------------
    localparam logic [5:0] LPS_SEL_RESET = 6'h00;
    localparam logic [1:0] LPS_FUN_RESET = 2'h0;
    localparam logic [5:0] LPS_POL_RESET = 6'h00;
    localparam logic [31:0] LPS_WORD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // strap capture happens in the first cycle after reset release
    typedef enum logic {
        LPS_PH_LATCH,
        LPS_PH_RUN
    } lps_phase_type;

    // drive request for one shared pin
    typedef struct packed {
        logic out;        // level driven when enabled
        logic oe;         // high while the pin is driven
        logic pullup_en;  // weak pull-up on
        logic ibuf_en;    // input buffer on
    } lps_pin_drive_type;

    // general-purpose side settings for the six pins
    typedef struct packed {
        logic [5:0] push_pull;  // 1 push-pull, 0 open-drain
        logic [5:0] dir_out;    // 1 output, 0 input
        logic [5:0] data_out;   // value to drive
    } lps_gpio_cfg_type;

    // loader override of the strap-derived defaults
    typedef struct packed {
        logic valid;
        logic [1:0] fun;
        logic [5:0] sel;
    } lps_loader_type;

    // address decode shared by the read and write paths
    function automatic logic lps_hits_config(
        input logic [15:0] addr
    );
        return addr == LPS_ADDR_PIN_CONFIG;
    endfunction

    // assemble the readable word; reserved bits read as zero
    function automatic logic [31:0] lps_config_word(
        input logic [1:0] fun,
        input logic [5:0] sel
    );
        logic [31:0] word;
        word = LPS_WORD_ZERO;
        word[LPS_FUN_LSB +: 2] = fun;
        word[LPS_SEL_LSB +: 6] = sel;
        return word;
    endfunction

endpackage
`default_nettype wire

// ---- verilog/lps_pin_driver.sv ----
`default_nettype none
// one shared pin: works out driver, pull-up and input buffer
// from the pin's mode; purely combinational, the caller registers
module lps_pin_driver
    import lps_pkg::*;
(
    input wire logic indicator_sel,
    input wire logic [1:0] function_code,
    input wire logic polarity_low,
    input wire logic indicator_active,
    input wire logic gpio_push_pull,
    input wire logic gpio_dir_out,
    input wire logic gpio_data,
    output var lps_pin_drive_type drive
);

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    always_comb begin
        drive = '0;
        if (indicator_sel) begin
            // indicator: no pull-up, no input buffer
            drive.pullup_en = 1'b0;
            drive.ibuf_en = 1'b0;
            if (function_code == LPS_FUN_PUSH_PULL) begin
                // push-pull, always driven
                drive.oe = 1'b1;
                drive.out = indicator_active;
            end else if (polarity_low) begin
                // open-drain, active low: sink when lit
                drive.oe = indicator_active;
                drive.out = 1'b0;
            end else begin
                // open-source, active high: source when lit
                drive.oe = indicator_active;
                drive.out = 1'b1;
            end
        end else begin
            // general purpose: strap plays no part here
            drive.pullup_en = 1'b1;
            drive.ibuf_en = 1'b1;
            if (gpio_dir_out && gpio_push_pull) begin
                drive.oe = 1'b1;
                drive.out = gpio_data;
            end else if (gpio_dir_out) begin
                // open-drain: low on 0, released on 1
                drive.oe = ~gpio_data;
                drive.out = 1'b0;
            end else begin
                // input: released
                drive.oe = 1'b0;
                drive.out = 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ---- bench/lps_assertions.sv ----
`default_nettype none
module lps_assertions
    import lps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [1:0] function_default_strap,
    input wire logic [5:0] select_default_strap,
    input wire logic [5:0] polarity_strap,
    input wire lps_loader_type loader,
    input wire logic [3:0][5:0] indicator_status,
    input wire lps_gpio_cfg_type gpio_cfg,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] pin_pullup_en,
    input wire logic [5:0] pin_ibuf_en,
    input wire logic [5:0] indicator_select_bits
);
    // ----
    // shadow config, rebuilt from the causes
    // ----
    logic [1:0] age;  // edges since release, saturates at 3
    logic [1:0] fun;
    logic [5:0] sel, pol, row, x_oe, x_out;
    logic [31:0] rword;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            age <= 2'h0;
        end else begin
            age <= (age == 2'h3) ? age : age + 2'h1;
            if (age == 2'h0) begin  // straps taken once only
                fun <= function_default_strap;
                sel <= select_default_strap;
                pol <= polarity_strap;
            end else if (loader.valid) begin  // loader beats software
                fun <= loader.fun;
                sel <= loader.sel;
            end else if (reg_wr && reg_addr == LPS_ADDR_PIN_CONFIG) begin
                fun <= reg_wdata[9:8];
                sel <= reg_wdata[5:0];
            end
        end
    end
    // expected drive: indicator pins from the status row, others gpio
    always_comb begin
        row = indicator_status[fun];
        x_oe = ~sel & gpio_cfg.dir_out
            & (gpio_cfg.push_pull | ~gpio_cfg.data_out);
        x_out = ~sel & gpio_cfg.push_pull & gpio_cfg.data_out;
        if (fun == LPS_FUN_PUSH_PULL) begin
            x_oe = x_oe | sel;
            x_out = x_out | (sel & row);
        end else begin
            x_oe = x_oe | (sel & row);
            x_out = x_out | (sel & ~pol);
        end
        rword = 32'h0;
        if (reg_addr == LPS_ADDR_PIN_CONFIG) begin
            rword = {22'h0, fun, 2'h0, sel};
        end
    end
    // ----
    // properties
    // ----
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_settled;
        age == 2'h3;
    endsequence
    sequence s_read;
        s_settled ##0 reg_rd;
    endsequence
    property p_ind_oe;
        s_settled |=> ((pin_oe ^ $past(x_oe)) & $past(sel)) == 6'h00;
    endproperty
    property p_ind_out;
        s_settled |=> ((pin_out ^ $past(x_out)) & pin_oe & $past(sel)) == 6'h00;
    endproperty
    property p_gpio_oe;
        s_settled |=> ((pin_oe ^ $past(x_oe)) & ~$past(sel)) == 6'h00;
    endproperty
    property p_gpio_out;
        s_settled |=> ((pin_out ^ $past(x_out)) & pin_oe & ~$past(sel)) == 6'h00;
    endproperty
    property p_ind_bufs;
        s_settled |=> ((pin_pullup_en | pin_ibuf_en) & $past(sel)) == 6'h00;
    endproperty
    property p_gpio_bufs;
        s_settled ##0 (sel == 6'h00)[*2] |-> (pin_pullup_en & pin_ibuf_en) == 6'h3f;
    endproperty
    property p_sel;
        s_settled |-> indicator_select_bits == sel;
    endproperty
    property p_rdata;
        s_read |=> reg_rvalid && reg_rdata == $past(rword);
    endproperty
    a_ind_oe: assert property (p_ind_oe)
        else $error("indicator enable wrong");
    a_ind_out: assert property (p_ind_out)
        else $error("indicator level wrong");
    a_gpio_oe: assert property (p_gpio_oe)
        else $error("gpio enable wrong");
    a_gpio_out: assert property (p_gpio_out)
        else $error("gpio level wrong");
    a_ind_bufs: assert property (p_ind_bufs)
        else $error("indicator pull-up or buffer on");
    a_gpio_bufs: assert property (p_gpio_bufs)
        else $error("gpio pull-up or buffer off");
    a_sel: assert property (p_sel)
        else $error("select bits wrong");
    a_rdata: assert property (p_rdata)
        else $error("read word wrong");
endmodule
`default_nettype wire

// ---- bench/lps_led_model.sv ----
`default_nettype none
// indicator lamps and the board around the six shared pins
module lps_led_model (
    input wire logic clk_sys,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] pin_pullup_en,
    output logic [5:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] last = 6'h00;  // level of the previous cycle
    // a floating pin flips every cycle so a stale read cannot match
    always_comb begin
        pin_level = (pin_oe & pin_out) | (~pin_oe & pin_pullup_en)
            | (~pin_oe & ~pin_pullup_en & ~last);
    end
    always_ff @(posedge clk_sys) begin
        last <= pin_level;
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`default_nettype none
module testbench
    import lps_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // stimulus and observed signals
    // ----
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_rvalid;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [1:0] fstrap = 2'h2;
    logic [5:0] sstrap = 6'h15, pstrap = 6'h0f;
    lps_loader_type loader = '0;
    logic [3:0][5:0] status = '0;
    lps_gpio_cfg_type gcfg = '0;
    logic [5:0] gpin, lvl, p_out, p_oe, p_pu, p_ib, sel;
    int error_cnt = 0;
    int compares = 0;
    lps_pin_select dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .function_default_strap(fstrap), .select_default_strap(sstrap),
        .polarity_strap(pstrap), .loader(loader), .indicator_status(status),
        .gpio_cfg(gcfg), .gpio_pin_in(gpin), .pin_in(lvl), .pin_out(p_out),
        .pin_oe(p_oe), .pin_pullup_en(p_pu), .pin_ibuf_en(p_ib),
        .indicator_select_bits(sel));
    lps_led_model lamps (.clk_sys(clk_sys), .pin_out(p_out), .pin_oe(p_oe),
        .pin_pullup_en(p_pu), .pin_level(lvl));
    // ----
    // tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic chk_pins(input string what, input logic [5:0] e, g);
        chk_word(what, {26'h0, e}, {26'h0, g});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask
    // read answer is waited for under a bound
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        int i;
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) tick(1);
        if (reg_rvalid !== 1'b1) begin
            error_cnt++;
            final_report();
        end
        chk_word("config read", e, reg_rdata);
        tick(1);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(4);
    endtask
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // ----
    // main sequence
    // ----
    initial begin
        int k;
        do_reset();
        rd(LPS_ADDR_PIN_CONFIG, 32'h0000_0215);
        chk_pins("select bits", 6'h15, sel);
        pstrap = 6'h30;  // a late strap change must not count
        status = {4{6'h3f}};
        tick(3);
        chk_pins("indicator levels", 6'h10, p_out & 6'h15);
        chk_pins("pull-ups", 6'h2a, p_pu);
        chk_pins("gpio inputs", 6'h2a, gpin);
        status = {6'h05, 6'h0a, 6'h14, 6'h21};
        // every function code, reserved bits written as ones
        for (k = 0; k < 4; k++) begin
            wr(LPS_ADDR_PIN_CONFIG, {22'h3fffff, k[1:0], 8'hff});
            tick(2);
            chk_pins("indicator enables", k == 3 ? 6'h3f : status[k], p_oe);
            rd(LPS_ADDR_PIN_CONFIG, {22'h0, k[1:0], 8'h3f});
        end
        chk_pins("push-pull levels", 6'h05, p_out);
        gcfg = {6'h03, 6'h0f, 6'h05};
        wr(LPS_ADDR_PIN_CONFIG, 32'h0000_0300);
        tick(3);
        chk_pins("gpio enables", 6'h0b, p_oe);
        chk_pins("gpio levels", 6'h01, p_out & p_oe);
        chk_pins("gpio inputs", 6'h35, gpin);
        loader = {1'b1, 2'h1, 6'h2a};
        wr(LPS_ADDR_PIN_CONFIG, 32'h0000_0011);
        loader.valid = 1'b0;
        rd(LPS_ADDR_PIN_CONFIG, 32'h0000_012a);
        wr(16'h01b8, 32'h0000_0000);
        rd(16'h01b8, 32'h0000_0000);
        rd(LPS_ADDR_PIN_CONFIG, 32'h0000_012a);
        fstrap = 2'h1;
        sstrap = 6'h3f;
        pstrap = 6'h3f;
        status = {4{6'h3f}};
        do_reset();
        rd(LPS_ADDR_PIN_CONFIG, 32'h0000_013f);
        chk_pins("indicator levels", 6'h00, p_out);
        final_report();
    end
endmodule
bind lps_pin_select lps_assertions chk (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .function_default_strap(function_default_strap),
    .select_default_strap(select_default_strap),
    .polarity_strap(polarity_strap), .loader(loader),
    .indicator_status(indicator_status), .gpio_cfg(gpio_cfg),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_ibuf_en(pin_ibuf_en), .indicator_select_bits(indicator_select_bits));
`default_nettype wire
